// ---- logic/rx_tick_divider.sv ----
// Oversample tick generator dividing the module clock
`timescale 1ns/1ps
`default_nettype none
module rx_tick_divider (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [15:0] div_in,
    output logic             tick_out
);
    logic [15:0] cnt_q;   // Clocks since last tick

    // Count to the reload value, then wrap; a new divisor applies to
    // the count in progress, wrapping at once if already passed
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= 16'h0000;
        end else if (cnt_q >= div_in) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // Registered one-cycle tick, sixteen per bit time
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= (cnt_q >= div_in);
        end
    end
endmodule
`default_nettype wire

// ---- logic/uart_rx_pkg.sv ----
// Shared constants for the serial receive recovery block
package uart_rx_pkg;
    // Clock and default line rate
    localparam int unsigned CLK_HZ     = 20_000_000;
    localparam int unsigned BAUD_DEF   = 9600;
    localparam int unsigned OVERSAMPLE = 16;
    // Divider reload: tick period is DIV + 1 clocks
    localparam logic [15:0] DIV_RST =
        16'(CLK_HZ / (OVERSAMPLE * BAUD_DEF) - 1);

    // Register byte offsets
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_DIV  = 4'h4;
    localparam logic [3:0] OFF_STAT = 4'h8;
    localparam logic [3:0] OFF_DATA = 4'hC;

    // Control field positions and reset value
    localparam int unsigned CTL_STANDBY  = 0;
    localparam int unsigned CTL_WAKE_ADR = 1;
    localparam int unsigned CTL_IDLE_SEL = 2;
    localparam int unsigned CTL_NINE     = 3;
    localparam int unsigned CTL_RX_EN    = 4;
    localparam int unsigned CTL_FULL_EN  = 5;
    localparam int unsigned CTL_IDLE_EN  = 6;
    localparam logic [6:0]  CTRL_RST     = 7'h00;

    // Status field positions
    localparam int unsigned STA_FULL  = 0;
    localparam int unsigned STA_IDLE  = 1;
    localparam int unsigned STA_NOISE = 2;
    localparam int unsigned STA_FRAME = 3;

    // Oversample tick numbers within one bit
    localparam logic [4:0] RT_FIRST  = 5'h01;
    localparam logic [4:0] RT_S3     = 5'h03;
    localparam logic [4:0] RT_S5     = 5'h05;
    localparam logic [4:0] RT_S7     = 5'h07;
    localparam logic [4:0] RT_V8     = 5'h08;
    localparam logic [4:0] RT_V10    = 5'h0A;
    localparam logic [4:0] RT_LAST   = 5'h10;
    // Next tick number after a resync, minus the edge tick
    localparam logic [4:0] RT_RESYNC = 5'h0C;

    // Data bit counts
    localparam logic [3:0] BITS_8 = 4'h8;
    localparam logic [3:0] BITS_9 = 4'h9;
    // Idle length in ticks, minus one: 10 or 11 bits
    localparam logic [7:0] IDLE_T8 = 8'(10 * OVERSAMPLE - 1);
    localparam logic [7:0] IDLE_T9 = 8'(11 * OVERSAMPLE - 1);
endpackage

// ---- logic/uart_rx_recovery_wakeup.sv ----
// Serial receive data recovery with standby wake-up and register slave
//
// How it works
// - Sample input at sixteen ticks per bit
// - Resync tick count on start and falling edge
// - Start search: low after three highs
// - Count ticks to sixteen from start edge
// - Start accepted on two lows; one high is noise
// - Failed start resets count and searches again
// - Data bit majority of ticks 8-10, noise
// - High start samples 8-10 only flag noise
// - Stop majority low gives framing error
// - Break without stop sets framing error
// - Framing error set with receive full
// - Standby suppresses all receiver requests
// - Address mark wakes and sets receive full
// - Waking idle sets neither idle nor full
// - Idle count starts after start or stop
// - Eight or nine bit data, ninth held
// - Idle flag after 10 or 11 high bits
// - Completed character loads buffer, sets full; standby keeps only address marks
`timescale 1ns/1ps
`default_nettype none
module uart_rx_recovery_wakeup (
    input  wire logic        MCLK_IN,
    input  wire logic        NRST_IN,
    input  wire logic        SERIAL_RECEIVE_INPUT_IN,
    input  wire logic [3:0]  AVS_ADDRESS_IN,
    input  wire logic        AVS_READ_IN,
    input  wire logic        AVS_WRITE_IN,
    input  wire logic [31:0] AVS_WRITEDATA_IN,
    input  wire logic [3:0]  AVS_BYTEENABLE_IN,
    output logic [31:0]      AVS_READDATA_OUT,
    output logic             AVS_WAITREQUEST_OUT,
    output logic             RX_REQUEST_OUT
);
    typedef enum logic [1:0] {
        ST_SEARCH,
        ST_START,
        ST_DATA,
        ST_STOP
    } rx_state_e;

    // Majority of three samples
    function automatic logic maj3(input logic [2:0] s);
        return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    // Samples disagree
    function automatic logic mixed3(input logic [2:0] s);
        return (|s) & ~(&s);
    endfunction

    // Address decode
    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        return a == o;
    endfunction

    logic        rst_meta_q;   // Reset release stage one
    logic        rst_n;        // Synchronised reset
    logic        rx_meta_q;    // Input synchroniser stage one
    logic        rx_q;         // Synchronised receive level
    logic        tick;         // Oversample tick
    logic        ack_q;        // Bus answer phase
    logic [6:0]  ctrl_q;       // Control register
    logic [15:0] div_q;        // Tick divider reload
    rx_state_e   state_q;      // Recovery state
    logic [4:0]  rt_q;         // Tick number in bit, 1..16
    logic [3:0]  bitc_q;       // Data bits taken
    logic [2:0]  hist_q;       // Last three search samples
    logic [2:0]  smp_q;        // Recent vote samples
    logic [1:0]  vrf_q;        // Start check samples at ticks 3 and 5
    logic [8:0]  sr_q;         // Receive shift register
    logic        noise_pend_q; // Noise seen in this character
    logic        prev_bit_q;   // Previous voted bit
    logic        edge_seen_q;  // Low seen in this bit
    logic [4:0]  edge_rt_q;    // Tick of that low
    logic        armed_q;      // Idle counting allowed
    logic [7:0]  idle_cnt_q;   // Consecutive high ticks
    logic        full_q;       // Receive full flag
    logic        idle_q;       // Idle flag
    logic        noise_q;      // Noise flag
    logic        frame_q;      // Framing error flag
    logic [7:0]  data_q;       // Receive buffer
    logic        ninth_q;      // Ninth received bit

    // Control fields
    wire standby   = ctrl_q[uart_rx_pkg::CTL_STANDBY];
    wire wake_adr  = ctrl_q[uart_rx_pkg::CTL_WAKE_ADR];
    wire idle_sel  = ctrl_q[uart_rx_pkg::CTL_IDLE_SEL];
    wire nine      = ctrl_q[uart_rx_pkg::CTL_NINE];
    wire rx_en     = ctrl_q[uart_rx_pkg::CTL_RX_EN];
    wire tk        = tick & rx_en;
    // Current three samples including this tick
    wire [2:0] cur3 = {smp_q[1:0], rx_q};
    // Start check: ticks 3 and 5 held, tick 7 live; ticks 4 and 6 play no part
    wire [2:0] st3 = {vrf_q, rx_q};
    wire [3:0] nbits = nine ? uart_rx_pkg::BITS_9 : uart_rx_pkg::BITS_8;
    // Top received bit lands in sr_q[8] in both lengths
    wire msb = sr_q[8];
    wire done = tk & (state_q == ST_STOP) & (rt_q == uart_rx_pkg::RT_V10);
    wire stop_low = ~maj3(cur3);
    wire start_go = tk & (state_q == ST_SEARCH) & (&hist_q) & ~rx_q;
    wire start_bad = tk & (state_q == ST_START)
        & (rt_q == uart_rx_pkg::RT_S7) & maj3(st3);
    wire to_data = tk & (state_q == ST_START) & (rt_q == uart_rx_pkg::RT_LAST);
    wire resync = prev_bit_q & edge_seen_q & ~maj3(cur3);
    wire [7:0] idle_lim = nine ? uart_rx_pkg::IDLE_T9 : uart_rx_pkg::IDLE_T8;
    wire idle_evt = tk & armed_q & rx_q & (idle_cnt_q == idle_lim);
    // Character kept unless standby and not an address mark
    wire accept = done & (~standby | (wake_adr & msb));
    wire wake = (done & standby & wake_adr & msb)
        | (idle_evt & standby & ~wake_adr);
    wire wr_go = AVS_WRITE_IN & ack_q;
    wire stat_clr = wr_go & hit(AVS_ADDRESS_IN, uart_rx_pkg::OFF_STAT)
        & AVS_BYTEENABLE_IN[0];

    // Reset released through two stages
    always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // Pin synchroniser; idle line is high
    always_ff @(posedge MCLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            rx_meta_q <= 1'b1;
            rx_q      <= 1'b1;
        end else begin
            rx_meta_q <= SERIAL_RECEIVE_INPUT_IN;
            rx_q      <= rx_meta_q;
        end
    end

    rx_tick_divider u_div (
        .clk_in   (MCLK_IN),
        .rst_n_in (rst_n),
        .div_in   (div_q),
        .tick_out (tick)
    );

    // One wait state per access keeps read data registered
    always_ff @(posedge MCLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (AVS_READ_IN | AVS_WRITE_IN) & ~ack_q;
        end
    end
    assign AVS_WAITREQUEST_OUT = (AVS_READ_IN | AVS_WRITE_IN) & ~ack_q;

    // Read mux captured in the wait cycle; unmapped reads give zero
    always_ff @(posedge MCLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            AVS_READDATA_OUT <= 32'h0000_0000;
        end else if (AVS_READ_IN & ~ack_q) begin
            case (AVS_ADDRESS_IN)
                uart_rx_pkg::OFF_CTRL: AVS_READDATA_OUT <= {25'h0, ctrl_q};
                uart_rx_pkg::OFF_DIV:  AVS_READDATA_OUT <= {16'h0, div_q};
                uart_rx_pkg::OFF_STAT: begin
                    AVS_READDATA_OUT <= {28'h0, frame_q, noise_q, idle_q, full_q};
                end
                uart_rx_pkg::OFF_DATA: AVS_READDATA_OUT <= {23'h0, ninth_q, data_q};
                default:               AVS_READDATA_OUT <= 32'h0000_0000;
            endcase
        end
    end

    // Control and divider writes; a wake in the same cycle wins
    // over a software write of the standby bit
    always_ff @(posedge MCLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= uart_rx_pkg::CTRL_RST;
            div_q  <= uart_rx_pkg::DIV_RST;
        end else begin
            if (wr_go & hit(AVS_ADDRESS_IN, uart_rx_pkg::OFF_CTRL)
                & AVS_BYTEENABLE_IN[0]) begin
                ctrl_q <= AVS_WRITEDATA_IN[6:0];
            end
            if (wake) begin
                ctrl_q[uart_rx_pkg::CTL_STANDBY] <= 1'b0;
            end
            if (wr_go & hit(AVS_ADDRESS_IN, uart_rx_pkg::OFF_DIV)) begin
                if (AVS_BYTEENABLE_IN[0]) begin
                    div_q[7:0] <= AVS_WRITEDATA_IN[7:0];
                end
                if (AVS_BYTEENABLE_IN[1]) begin
                    div_q[15:8] <= AVS_WRITEDATA_IN[15:8];
                end
            end
        end
    end

    // Bit sequencing: search, start check, data bits, stop
    always_ff @(posedge MCLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_SEARCH;
            rt_q    <= 5'h00;
            bitc_q  <= 4'h0;
            hist_q  <= 3'h0;
        end else if (!rx_en) begin
            // Disabled receiver forgets any partial character
            state_q <= ST_SEARCH;
            rt_q    <= 5'h00;
            hist_q  <= 3'h0;
        end else if (tick) begin
            case (state_q)
                ST_SEARCH: begin
                    // Free running search, no bit timing yet
                    hist_q <= {hist_q[1:0], rx_q};
                    if (start_go) begin
                        state_q <= ST_START;
                        rt_q    <= uart_rx_pkg::RT_FIRST;
                    end
                end
                ST_START: begin
                    if (start_bad) begin
                        // Line must show three highs again
                        state_q <= ST_SEARCH;
                        rt_q    <= 5'h00;
                        hist_q  <= 3'h0;
                    end else if (rt_q == uart_rx_pkg::RT_LAST) begin
                        state_q <= ST_DATA;
                        rt_q    <= uart_rx_pkg::RT_FIRST;
                        bitc_q  <= 4'h0;
                    end else begin
                        rt_q <= rt_q + 5'h01;
                    end
                end
                ST_DATA: begin
                    if (rt_q == uart_rx_pkg::RT_V10 && resync) begin
                        // Realign so the falling edge becomes tick one
                        rt_q <= uart_rx_pkg::RT_RESYNC - edge_rt_q;
                    end else if (rt_q == uart_rx_pkg::RT_LAST) begin
                        rt_q   <= uart_rx_pkg::RT_FIRST;
                        bitc_q <= bitc_q + 4'h1;
                        if (bitc_q == nbits - 4'h1) begin
                            state_q <= ST_STOP;
                        end
                    end else begin
                        rt_q <= rt_q + 5'h01;
                    end
                end
                ST_STOP: begin
                    if (rt_q == uart_rx_pkg::RT_V10) begin
                        // Stop seen high counts as the three highs
                        state_q <= ST_SEARCH;
                        rt_q    <= 5'h00;
                        hist_q  <= {3{~stop_low}};
                    end else begin
                        rt_q <= rt_q + 5'h01;
                    end
                end
                default: begin
                    state_q <= ST_SEARCH;
                end
            endcase
        end
    end

    // Sample capture, voting, shifting and noise collection
    always_ff @(posedge MCLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            smp_q        <= 3'h0;
            vrf_q        <= 2'h0;
            sr_q         <= 9'h000;
            noise_pend_q <= 1'b0;
            prev_bit_q   <= 1'b0;
        end else if (tk) begin
            if (state_q != ST_SEARCH) begin
                smp_q <= cur3;
            end
            // Hold the early start samples until the tick 7 decision
            if (state_q == ST_START && rt_q == uart_rx_pkg::RT_S3) begin
                vrf_q[1] <= rx_q;
            end
            if (state_q == ST_START && rt_q == uart_rx_pkg::RT_S5) begin
                vrf_q[0] <= rx_q;
            end
            if (start_go) begin
                noise_pend_q <= 1'b0;
            end
            if (state_q == ST_START && rt_q == uart_rx_pkg::RT_S7
                && $onehot(st3)) begin
                noise_pend_q <= 1'b1;
            end
            if (state_q == ST_START && rt_q == uart_rx_pkg::RT_V10
                && |cur3) begin
                noise_pend_q <= 1'b1;
            end
            if (to_data) begin
                prev_bit_q <= 1'b0;
            end
            if (state_q == ST_DATA && rt_q == uart_rx_pkg::RT_V10) begin
                sr_q       <= {maj3(cur3), sr_q[8:1]};
                prev_bit_q <= maj3(cur3);
                if (mixed3(cur3)) begin
                    noise_pend_q <= 1'b1;
                end
            end
        end
    end

    // Where the first low of a bit falls, for resync
    always_ff @(posedge MCLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            edge_seen_q <= 1'b0;
            edge_rt_q   <= 5'h00;
        end else if (tk) begin
            if (rt_q == uart_rx_pkg::RT_LAST) begin
                edge_seen_q <= 1'b0;
            end else if (!edge_seen_q && !rx_q) begin
                edge_seen_q <= 1'b1;
                edge_rt_q   <= rt_q;
            end
        end
    end

    // Idle counter; armed at reset so an idle line can wake at once
    always_ff @(posedge MCLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            armed_q    <= 1'b1;
            idle_cnt_q <= 8'h00;
        end else if (tk) begin
            if (idle_evt) begin
                armed_q    <= 1'b0;
                idle_cnt_q <= 8'h00;
            end else begin
                if ((to_data && !idle_sel) || (done && idle_sel)) begin
                    armed_q <= 1'b1;
                end
                if (!rx_q) begin
                    idle_cnt_q <= 8'h00;
                end else if (armed_q) begin
                    idle_cnt_q <= idle_cnt_q + 8'h01;
                end
            end
        end
    end

    // Status flags: hardware set wins over a write-one clear
    always_ff @(posedge MCLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            full_q  <= 1'b0;
            idle_q  <= 1'b0;
            noise_q <= 1'b0;
            frame_q <= 1'b0;
        end else begin
            if (accept) begin
                full_q <= 1'b1;
            end else if (stat_clr && AVS_WRITEDATA_IN[uart_rx_pkg::STA_FULL]) begin
                full_q <= 1'b0;
            end
            if (idle_evt && !standby) begin
                idle_q <= 1'b1;
            end else if (stat_clr && AVS_WRITEDATA_IN[uart_rx_pkg::STA_IDLE]) begin
                idle_q <= 1'b0;
            end
            if (accept && (noise_pend_q || mixed3(cur3))) begin
                noise_q <= 1'b1;
            end else if (stat_clr && AVS_WRITEDATA_IN[uart_rx_pkg::STA_NOISE]) begin
                noise_q <= 1'b0;
            end
            // Break has no stop bit, so this also catches it
            if (accept && stop_low) begin
                frame_q <= 1'b1;
            end else if (stat_clr && AVS_WRITEDATA_IN[uart_rx_pkg::STA_FRAME]) begin
                frame_q <= 1'b0;
            end
        end
    end

    // Receive buffer; eight-bit mode copies bit 7 into the ninth
    always_ff @(posedge MCLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            data_q  <= 8'h00;
            ninth_q <= 1'b0;
        end else if (accept) begin
            data_q  <= nine ? sr_q[7:0] : sr_q[8:1];
            ninth_q <= sr_q[8];
        end
    end

    // Service request, masked while in standby
    assign RX_REQUEST_OUT = ~standby
        & ((full_q & ctrl_q[uart_rx_pkg::CTL_FULL_EN])
        | (idle_q & ctrl_q[uart_rx_pkg::CTL_IDLE_EN]));

    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!rst_n);

    sequence s_start_go;
        start_go;
    endsequence
    sequence s_start_live;
        (state_q == ST_START) [*2];
    endsequence

    property p_tick_gap;
        tick && div_q != 16'h0000 |=> !tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick too close");

    property p_start_seen;
        s_start_go |=> rt_q == uart_rx_pkg::RT_FIRST ##0 s_start_live;
    endproperty
    a_start_seen: assert property (p_start_seen) else $error("start lost");

    property p_rt_range;
        rt_q <= uart_rx_pkg::RT_LAST;
    endproperty
    a_rt_range: assert property (p_rt_range) else $error("tick count high");

    property p_start_fail;
        start_bad && rx_en |=> state_q == ST_SEARCH && rt_q == 5'h00;
    endproperty
    a_start_fail: assert property (p_start_fail) else $error("bad start kept");

    property p_data_noise;
        tk && state_q == ST_DATA && rt_q == uart_rx_pkg::RT_V10
            && mixed3(cur3) |=> noise_pend_q;
    endproperty
    a_data_noise: assert property (p_data_noise) else $error("noise missed");

    property p_frame_full;
        accept && stop_low |=> full_q && frame_q;
    endproperty
    a_frame_full: assert property (p_frame_full) else $error("frame not with full");

    property p_standby_quiet;
        standby |-> !RX_REQUEST_OUT;
    endproperty
    a_standby_quiet: assert property (p_standby_quiet) else $error("request in standby");

    property p_addr_wake;
        done && standby && wake_adr && msb |=> full_q && !standby;
    endproperty
    a_addr_wake: assert property (p_addr_wake) else $error("address wake failed");

    property p_idle_wake;
        idle_evt && standby && !wake_adr && !done |=> !standby && !$rose(idle_q);
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle wake wrong");
endmodule
`default_nettype wire

// ---- tb/serial_tx_model.sv ----
// Behavioural remote transmitter driving the serial receive line
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model #(
    parameter int BIT_CLKS = 32 // Clocks per bit, equal to the receiver rate
) (
    input  wire logic clk_in,
    output logic      line_out
);
    initial line_out = 1'b1; // Line idles high between frames

    // Start, data LSB first, stop; gb picks a bit (-1 start) for a one-tick glitch
    task automatic send(input logic [8:0] d, input int nb, input logic stp, input int gb);
        logic b;
        for (int i = 0; i <= nb + 1; i++) begin
            b = (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : stp;
            // Exact bit period, so all stop samples land inside the stop bit
            for (int c = 0; c < BIT_CLKS; c++) begin
                @(posedge clk_in);
                line_out <= (i == gb + 1 && c >= 16 && c < 18) ? ~b : b;
            end
        end
    endtask

    // High line for n bit times
    task automatic idle(input int n);
        @(posedge clk_in);
        line_out <= 1'b1;
        repeat (n * BIT_CLKS - 1) @(posedge clk_in);
    endtask

    // Short low spike, too short to pass start verification
    task automatic pulse(input int n);
        @(posedge clk_in);
        line_out <= 1'b0;
        repeat (n) @(posedge clk_in);
        line_out <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the serial receive recovery block
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [3:0]  A_CT = uart_rx_pkg::OFF_CTRL; // Register offsets
    localparam logic [3:0]  A_ST = uart_rx_pkg::OFF_STAT;
    localparam logic [3:0]  A_DT = uart_rx_pkg::OFF_DATA;
    localparam logic [31:0] ON   = 32'h0000_0001;
    localparam logic [31:0] EN   = (ON << uart_rx_pkg::CTL_RX_EN) | (ON << uart_rx_pkg::CTL_FULL_EN);
    localparam logic [31:0] SB   = ON << uart_rx_pkg::CTL_STANDBY;
    localparam logic [31:0] WK   = ON << uart_rx_pkg::CTL_WAKE_ADR;
    localparam logic [31:0] NI   = ON << uart_rx_pkg::CTL_NINE;
    localparam logic [31:0] IE   = ON << uart_rx_pkg::CTL_IDLE_EN;
    localparam logic [31:0] IL   = ON << uart_rx_pkg::CTL_IDLE_SEL;
    localparam logic [31:0] FL   = ON << uart_rx_pkg::STA_FULL;
    localparam logic [31:0] ID   = ON << uart_rx_pkg::STA_IDLE;
    localparam logic [31:0] NZ   = ON << uart_rx_pkg::STA_NOISE;
    localparam logic [31:0] FR   = ON << uart_rx_pkg::STA_FRAME;
    logic        mclk, nrst, rxd, rd, wr; // Clock, reset, line, strobes
    logic [3:0]  addr;                    // Register byte address
    logic [31:0] wdata, rdata, v;         // Write data, read data, last read
    logic        waitreq, req;            // Bus stall and receiver request
    logic [3:0]  be = 4'hF;               // Byte lanes, all on unless a test says not
    int          failures, samples_checked;

    uart_rx_recovery_wakeup u_uart_rx_recovery_wakeup (
        .MCLK_IN(mclk), .NRST_IN(nrst), .SERIAL_RECEIVE_INPUT_IN(rxd),
        .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
        .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata),
        .AVS_WAITREQUEST_OUT(waitreq), .RX_REQUEST_OUT(req));
    serial_tx_model u_serial_tx_model (.clk_in(mclk), .line_out(rxd));

    // Free-running 20 MHz clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Report counts and verdict, then stop
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Compare one value; unknowns never match
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Avalon cycle: hold until waitrequest is sampled low, take data there
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge mclk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        v = rdata;
        if (n >= 50) failures++;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge mclk);
    endtask

    // Read a register and compare
    task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, e, v);
    endtask

    // One character, a bit of idle, then status and data readback
    task automatic frame(input logic [8:0] d, input int nb, input logic stp, input int gb,
                         input logic [31:0] es, input logic [31:0] ed);
        u_serial_tx_model.send(d, nb, stp, gb);
        u_serial_tx_model.idle(1);
        rdchk(A_ST, es, "status");
        rdchk(A_DT, ed, "data");
        bus(1'b1, A_ST, 32'h0000_000F);
    endtask

    // Watchdog well beyond the expected run of about 5400 clocks
    initial begin
        repeat (40000) @(posedge mclk);
        failures++;
        close_out();
    end

    // Main sequence
    initial begin
        {rd, wr, addr, wdata, nrst, failures, samples_checked} = '0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        rdchk(A_CT, 32'h0000_0000, "ctrl reset");
        rdchk(uart_rx_pkg::OFF_DIV, {16'h0000, uart_rx_pkg::DIV_RST}, "div reset");
        rdchk(A_ST, 32'h0000_0000, "stat reset");
        bus(1'b1, 4'h2, 32'hFFFF_FFFF);
        rdchk(4'h2, 32'h0000_0000, "unmapped");
        be <= 4'hE;
        bus(1'b1, A_CT, 32'h0000_007F);
        be <= 4'hF;
        rdchk(A_CT, 32'h0000_0000, "lane off");
        bus(1'b1, uart_rx_pkg::OFF_DIV, 32'h0000_0001);
        bus(1'b1, A_CT, EN);
        u_serial_tx_model.idle(2);
        u_serial_tx_model.send(9'h0A5, 8, 1'b1, 99);
        u_serial_tx_model.idle(1);
        rdchk(A_DT, 32'h0000_01A5, "data 8 bit");
        chk("request", 32'(1), 32'(req));
        bus(1'b1, A_CT, EN | SB);
        chk("request standby", 32'(0), 32'(req));
        bus(1'b1, A_CT, EN);
        bus(1'b1, A_ST, 32'h0000_000F);
        frame(9'h03C, 8, 1'b1, 3, FL | NZ, 32'h0000_003C);
        frame(9'h0B5, 8, 1'b1, 5, FL | NZ, 32'h0000_01B5);
        frame(9'h042, 8, 1'b1, -1, FL | NZ, 32'h0000_0042);
        frame(9'h055, 8, 1'b0, 99, FL | FR, 32'h0000_0055);
        frame(9'h000, 8, 1'b0, 99, FL | FR, 32'h0000_0000);
        u_serial_tx_model.idle(2);
        u_serial_tx_model.pulse(4);
        u_serial_tx_model.idle(2);
        rdchk(A_ST, 32'h0000_0000, "false start");
        frame(9'h081, 8, 1'b1, 99, FL, 32'h0000_0181);
        bus(1'b1, A_CT, EN | NI);
        frame(9'h0AA, 9, 1'b1, 99, FL, 32'h0000_00AA);
        bus(1'b1, A_CT, EN | NI | SB | WK);
        frame(9'h080, 9, 1'b1, 99, 32'h0000_0000, 32'h0000_00AA);
        u_serial_tx_model.send(9'h100, 9, 1'b1, 99);
        u_serial_tx_model.idle(1);
        rdchk(A_ST, FL, "mark status");
        rdchk(A_CT, EN | NI | WK, "mark wake");
        bus(1'b1, A_CT, EN | SB | IE);
        bus(1'b1, A_ST, 32'h0000_000F);
        u_serial_tx_model.idle(12);
        rdchk(A_CT, EN | IE, "idle wake");
        rdchk(A_ST, 32'h0000_0000, "idle wake status");
        u_serial_tx_model.send(9'h033, 8, 1'b1, 99);
        u_serial_tx_model.idle(12);
        rdchk(A_ST, FL | ID, "idle flag");
        bus(1'b1, A_CT, EN | IE | IL);
        bus(1'b1, A_ST, 32'h0000_000F);
        u_serial_tx_model.send(9'h0FF, 8, 1'b1, 99);
        u_serial_tx_model.idle(2);
        rdchk(A_ST, FL, "idle after stop");
        close_out();
    end
endmodule
`default_nettype wire
